// ==== logic/cam_host_pkg.sv ====
// Constants for the two-wire host register port.
package cam_host_pkg;
    localparam logic [6:0] ADDR7_SEL_LOW = 7'h3C;   // 0x78 written as a byte address.
    localparam logic [6:0] ADDR7_SEL_HIGH = 7'h3D;  // 0x7A written as a byte address.
    localparam int REG_ADDR_W = 16;
    localparam int REG_DATA_W = 16;
    localparam int WORD_INDEX_W = 15;               // 32K registers of 16 bits.
    localparam logic [3:0] BIT_COUNT_LAST = 4'h7;
    localparam logic [3:0] BIT_COUNT_FULL = 4'h8;   // Rising clock edges in one received byte.
    localparam logic [1:0] BYTE_ADDR_HI = 2'h0;
    localparam logic [1:0] BYTE_ADDR_LO = 2'h1;
    localparam logic [1:0] BYTE_DATA_HI = 2'h2;
    localparam logic [1:0] BYTE_DATA_LO = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV_ADDR,
        ST_ACK,
        ST_RX,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } port_state_t;
endpackage

// ==== logic/camera_host_register_port.sv ====
// Two-wire slave port giving a host access to a 16-bit register space.
`timescale 1ns/100ps

// Function
// R1: The port answers at byte address 0x78 when addr_sel_i is low and 0x7A when high.
// R2: Register addresses are 16-bit byte addresses with even alignment giving 32K 16-bit words.
// R3: Both host port and microcontroller can reach every register or RAM location on the shared bus.
// R4: When both request the internal bus in one cycle, the host port is granted.
// R5: Indirect window registers are ordinary locations reached through the same shared bus.
// R6: The host makes the serial clock; this port only samples it and never starts a transfer.
// R7: The port only pulls the data line low and releases it otherwise, as the phase dictates.
// R8: This port has no standby gating and keeps working while power is applied.
// R9: Patch memory retention is outside this port; standby does not touch it here.
// R10: Host writes go out like any other write; firmware may later overwrite them.
// R11: A transaction is a 16-bit address then 16-bit data, high byte first, each byte acknowledged.
module camera_host_register_port
    import cam_host_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic addr_sel_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic mcu_req_i,
    input wire logic mcu_we_i,
    input wire logic [WORD_INDEX_W-1:0] mcu_addr_i,
    input wire logic [REG_DATA_W-1:0] mcu_wdata_i,
    output logic mcu_gnt_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [WORD_INDEX_W-1:0] mem_addr_o,
    output logic [REG_DATA_W-1:0] mem_wdata_o,
    input wire logic [REG_DATA_W-1:0] mem_rdata_i,
    output logic [REG_DATA_W-1:0] rdata_o,
    output logic host_busy_o
);

    // ----------------------------------------
    // Bus line sampling and condition detection
    // ----------------------------------------
    logic scl_ff, sda_ff, nxt_scl, nxt_sda;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    // Previous line levels are kept to find edges and start/stop.
    always_comb begin
        nxt_scl = scl_i;
        nxt_sda = sda_i;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_ff <= nxt_scl;
            sda_ff <= nxt_sda;
        end
    end

    // The host owns the clock; every step follows its edges. [R6]
    assign scl_rise = scl_i && !scl_ff;
    assign scl_fall = !scl_i && scl_ff;
    assign start_cond = scl_i && scl_ff && sda_ff && !sda_i;
    assign stop_cond = scl_i && scl_ff && !sda_ff && sda_i;

    // ----------------------------------------
    // Protocol state
    // ----------------------------------------
    port_state_t state_ff, nxt_state;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic [1:0] byte_idx_ff, nxt_byte_idx;
    logic rd_ff, nxt_rd;
    logic [REG_ADDR_W-1:0] addr_ff, nxt_addr;
    logic [REG_DATA_W-1:0] wdata_ff, nxt_wdata;
    logic [REG_DATA_W-1:0] rdata_ff, nxt_rdata;
    logic hi_sent_ff, nxt_hi_sent;
    logic drive_low_ff, nxt_drive_low;
    logic wr_pend_ff, nxt_wr_pend;
    logic rd_pend_ff, nxt_rd_pend;
    logic host_req, host_gnt;
    logic [6:0] my_addr;

    assign my_addr = addr_sel_i ? ADDR7_SEL_HIGH : ADDR7_SEL_LOW; // [R1]
    assign host_req = wr_pend_ff || rd_pend_ff;
    assign host_gnt = host_req; // Host never waits for the microcontroller. [R4]

    // Next state of the serial engine.
    always_comb begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_byte_idx = byte_idx_ff;
        nxt_rd = rd_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_rdata = rdata_ff;
        nxt_hi_sent = hi_sent_ff;
        nxt_drive_low = drive_low_ff;
        nxt_wr_pend = wr_pend_ff && !host_gnt;
        nxt_rd_pend = rd_pend_ff && !host_gnt;
        if (rd_pend_ff) begin
            nxt_rdata = mem_rdata_i;
        end
        if (wr_pend_ff) begin
            nxt_addr = addr_ff + 16'h0002; // The write has used the pointer; bursts move on now. [R11]
        end
        if (start_cond) begin
            nxt_state = ST_DEV_ADDR;
            nxt_bit_cnt = 4'h0;
            nxt_drive_low = 1'b0;
        end else if (stop_cond) begin
            nxt_state = ST_IDLE;
            nxt_drive_low = 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_drive_low = 1'b0;
                end
                ST_DEV_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[6:0], sda_i};
                        nxt_bit_cnt = bit_cnt_ff + 4'h1; // Counted on the sampling edge, so a start's fall is not a bit.
                    end
                    if (scl_fall) begin
                        if (bit_cnt_ff == BIT_COUNT_FULL) begin
                            nxt_bit_cnt = 4'h0;
                            if (state_ff == ST_DEV_ADDR) begin
                                if (shift_ff[7:1] == my_addr) begin // [R1]
                                    nxt_rd = shift_ff[0];
                                    nxt_state = ST_ACK;
                                    nxt_drive_low = 1'b1; // [R7]
                                    if (shift_ff[0]) begin
                                        nxt_hi_sent = 1'b0;
                                        nxt_rd_pend = 1'b1;
                                    end else begin
                                        nxt_byte_idx = BYTE_ADDR_HI;
                                    end
                                end else begin
                                    nxt_state = ST_IGNORE;
                                end
                            end else begin
                                // Collect address then data, high byte first. [R11]
                                case (byte_idx_ff)
                                    BYTE_ADDR_HI: nxt_addr[15:8] = shift_ff;
                                    BYTE_ADDR_LO: nxt_addr[7:0] = shift_ff;
                                    BYTE_DATA_HI: nxt_wdata[15:8] = shift_ff;
                                    default: begin
                                        nxt_wdata[7:0] = shift_ff;
                                        nxt_wr_pend = 1'b1; // [R10]
                                    end
                                endcase
                                nxt_byte_idx = (byte_idx_ff == BYTE_DATA_LO) ? BYTE_DATA_HI : byte_idx_ff + 2'h1;
                                nxt_state = ST_ACK;
                                nxt_drive_low = 1'b1; // Each byte acknowledged. [R11]
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        nxt_bit_cnt = 4'h0;
                        if (rd_ff) begin
                            nxt_state = ST_TX;
                            nxt_shift = hi_sent_ff ? rdata_ff[7:0] : rdata_ff[15:8];
                            nxt_drive_low = hi_sent_ff ? !rdata_ff[7] : !rdata_ff[15];
                        end else begin
                            nxt_state = ST_RX;
                            nxt_drive_low = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_ff == BIT_COUNT_LAST) begin
                            nxt_state = ST_TX_ACK;
                            nxt_drive_low = 1'b0; // Release for the host acknowledge.
                        end else begin
                            nxt_bit_cnt = bit_cnt_ff + 4'h1;
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_drive_low = !shift_ff[6]; // Ones are sent by releasing. [R7]
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        if (sda_i) begin
                            nxt_state = ST_IGNORE; // Host ended the read.
                        end else if (hi_sent_ff) begin
                            nxt_hi_sent = 1'b0;
                            nxt_addr = addr_ff + 16'h0002;
                            nxt_rd_pend = 1'b1;
                        end else begin
                            nxt_hi_sent = 1'b1;
                        end
                    end
                    if (scl_fall && state_ff == ST_TX_ACK) begin
                        nxt_bit_cnt = 4'h0;
                        nxt_state = ST_TX;
                        nxt_shift = hi_sent_ff ? rdata_ff[7:0] : rdata_ff[15:8];
                        nxt_drive_low = hi_sent_ff ? !rdata_ff[7] : !rdata_ff[15];
                    end
                end
                ST_IGNORE: begin
                    nxt_drive_low = 1'b0;
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_drive_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            byte_idx_ff <= 2'h0;
            rd_ff <= 1'b0;
            addr_ff <= 16'h0000;
            wdata_ff <= 16'h0000;
            rdata_ff <= 16'h0000;
            hi_sent_ff <= 1'b0;
            drive_low_ff <= 1'b0;
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
            byte_idx_ff <= nxt_byte_idx;
            rd_ff <= nxt_rd;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            rdata_ff <= nxt_rdata;
            hi_sent_ff <= nxt_hi_sent;
            drive_low_ff <= nxt_drive_low;
            wr_pend_ff <= nxt_wr_pend;
            rd_pend_ff <= nxt_rd_pend;
        end
    end

    // ----------------------------------------
    // Pins and shared internal bus
    // ----------------------------------------
    // Open-drain: output level is always low, only the enable moves. [R7]
    assign sda_o = 1'b0;
    assign sda_oe_o = drive_low_ff;

    // Host wins the shared bus; the window registers sit behind it too. [R3] [R4] [R5]
    always_comb begin
        mcu_gnt_o = mcu_req_i && !host_req;
        mem_req_o = host_req || mcu_req_i;
        mem_we_o = host_req ? wr_pend_ff : mcu_we_i;
        mem_addr_o = host_req ? addr_ff[WORD_INDEX_W:1] : mcu_addr_i; // [R2]
        mem_wdata_o = host_req ? wdata_ff : mcu_wdata_i;
    end

    assign rdata_o = rdata_ff;
    assign host_busy_o = (state_ff != ST_IDLE) && (state_ff != ST_IGNORE); // No standby gating. [R8] [R9]

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence ack_drive_s;
        state_ff == ST_ACK;
    endsequence

    host_first_a: assert property (@(posedge clk_i) disable iff (reset_i)
        host_req && mcu_req_i |-> !mcu_gnt_o && mem_we_o == wr_pend_ff)
        else $error("Microcontroller granted over host."); // [R4]
    open_drain_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !sda_o) else $error("Data line driven high."); // [R7]
    ack_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ack_drive_s |-> sda_oe_o) else $error("Acknowledge not driven."); // [R11]
    addr_match_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(state_ff == ST_ACK) && $past(state_ff) == ST_DEV_ADDR |-> $past(shift_ff[7:1]) == my_addr)
        else $error("Acknowledged wrong address."); // [R1]
    write_issue_a: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_pend_ff |-> mem_req_o && mem_we_o ##1 !wr_pend_ff)
        else $error("Write not issued."); // [R10]
    word_addr_a: assert property (@(posedge clk_i) disable iff (reset_i)
        host_req |-> mem_addr_o == addr_ff[15:1]) else $error("Word index wrong."); // [R2]
    no_master_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state_ff == ST_IDLE && !start_cond |=> state_ff == ST_IDLE) else $error("Transfer began unprompted."); // [R6]
    idle_release_a: assert property (@(posedge clk_i) disable iff (reset_i)
        stop_cond |=> !sda_oe_o) else $error("Line held after stop."); // [R7]
endmodule

// ==== verification/host_model.sv ====
// Bus master model of the host that clocks the two-wire port and drives data open-drain.
`timescale 1ns/100ps

module host_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // Both lines start released; the pull-ups hold them high.
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // A third of a bit of four system clocks keeps every phase well above the port's minimum.
    task automatic step();
        repeat (4) @(negedge clk_i);
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start_cond();
        sda_low_o = 1'b0;
        step();
        scl_o = 1'b1;
        step();
        sda_low_o = 1'b1;
        step();
        scl_o = 1'b0;
        step();
    endtask

    // Stop: data rises while the clock is high.
    task automatic stop_cond();
        sda_low_o = 1'b1;
        step();
        scl_o = 1'b1;
        step();
        sda_low_o = 1'b0;
        step();
    endtask

    // One clock pulse; data changes only while the clock is low, and the line is sampled high.
    task automatic pulse(input logic pull, output logic level);
        sda_low_o = pull;
        step();
        scl_o = 1'b1;
        step();
        level = sda_i;
        scl_o = 1'b0;
        step();
    endtask

    // Send a byte most significant bit first, then release the line for the acknowledge.
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic level;
        for (int i = 7; i >= 0; i--) begin
            pulse(~b[i], level);
        end
        pulse(1'b0, level);
        acked = ~level;
    endtask

    // Receive a byte, then acknowledge it or leave the slot released.
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic level;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b0, level);
            b[i] = level;
        end
        pulse(ack, level);
    endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the host register port with a host model and a word memory.
`timescale 1ns/100ps

module testbench
    import cam_host_pkg::*;
;
    logic clk_i, reset_i, addr_sel_i, scl, host_low, sda_o, sda_oe, mcu_gnt, mem_req, mem_we, host_busy;
    logic mcu_req, mcu_we;
    logic host_won = 1'b0;
    logic [WORD_INDEX_W-1:0] mcu_addr, mem_addr;
    logic [REG_DATA_W-1:0] mcu_wdata, mem_wdata, mem_rdata, rdata;
    logic [REG_DATA_W-1:0] mem [0:(1<<WORD_INDEX_W)-1];
    int bad_count = 0;
    int n_checks = 0;
    wire logic sda_line;

    // The pull-up wins unless either party pulls the line low.
    assign sda_line = ~(host_low | sda_oe);
    assign mem_rdata = mem[mem_addr];

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Shared memory behind the port's bus.
    always @(posedge clk_i) begin
        if (mem_req && mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    host_model host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(host_low));

    camera_host_register_port dut (.clk_i(clk_i), .reset_i(reset_i), .addr_sel_i(addr_sel_i), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe), .mcu_req_i(mcu_req), .mcu_we_i(mcu_we),
        .mcu_addr_i(mcu_addr), .mcu_wdata_i(mcu_wdata), .mcu_gnt_o(mcu_gnt), .mem_req_o(mem_req),
        .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
        .rdata_o(rdata), .host_busy_o(host_busy));

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watches the data driver and the cycle in which the host write reaches the bus.
    always @(negedge clk_i) begin
        if (sda_oe) check(sda_o === 1'b0, "data line driven high");
        if (mem_req && mem_we && host_busy && mem_wdata === 16'hC0DE) begin
            host_won = 1'b1;
            check(mcu_gnt === 1'b0, "controller granted over host");
        end
    end

    task automatic put(input logic [7:0] b, inout logic acks);
        logic a;
        host.send_byte(b, a);
        acks = acks & a;
    endtask

    // One write transaction of two words; acks is low if any byte went unacknowledged.
    task automatic host_write(input logic [6:0] dev, input logic [15:0] addr, input logic [31:0] words,
        output logic acks);
        acks = 1'b1;
        host.start_cond();
        put({dev, 1'b0}, acks);
        put(addr[15:8], acks);
        put(addr[7:0], acks);
        for (int i = 3; i >= 0; i--) put(words[i*8 +: 8], acks);
        host.stop_cond();
    endtask

    // Pointer write, repeated start and two words read back, the last byte left unacknowledged.
    task automatic sc_read(input logic [15:0] addr, input logic [31:0] words);
        logic acks;
        logic [31:0] got;
        acks = 1'b1;
        host.start_cond();
        put({ADDR7_SEL_LOW, 1'b0}, acks);
        put(addr[15:8], acks);
        put(addr[7:0], acks);
        host.start_cond();
        put({ADDR7_SEL_LOW, 1'b1}, acks);
        for (int i = 3; i >= 0; i--) host.recv_byte(i != 0, got[i*8 +: 8]);
        host.stop_cond();
        check(acks === 1'b1, "read not acknowledged");
        check(got === words, "read data differs");
        check(rdata === words[15:0], "held read word differs");
    endtask

    // Both select levels, the top of the space, and a foreign address that must be ignored.
    task automatic sc_address();
        logic acks;
        logic [15:0] addr;
        for (int s = 0; s < 2; s++) begin
            addr = s ? 16'hFFFC : 16'h0040;
            @(negedge clk_i);
            addr_sel_i = s[0];
            host_write(s ? ADDR7_SEL_HIGH : ADDR7_SEL_LOW, addr, 32'h1234_5678 + s, acks);
            check(acks === 1'b1, "own address not acknowledged");
            check(mem[addr[15:1]] === 16'h1234, "first word misplaced");
            check(mem[addr[15:1] + 1] === 16'h5678 + s, "second word misplaced");
            host_write(s ? ADDR7_SEL_LOW : ADDR7_SEL_HIGH, addr, 32'hDEAD_BEEF, acks);
            check(acks === 1'b0, "foreign address acknowledged");
            check(mem[addr[15:1]] === 16'h1234, "foreign write landed");
        end
        addr_sel_i = 1'b0;
    endtask

    // Controller writes the same word throughout a host write: host first, controller after.
    task automatic sc_arbitration();
        logic acks;
        @(negedge clk_i);
        mcu_req = 1'b1;
        mcu_we = 1'b1;
        mcu_addr = 15'h0030;
        mcu_wdata = 16'h0F0F;
        host_write(ADDR7_SEL_LOW, 16'h0060, 32'hC0DE_C0DE, acks);
        repeat (4) @(negedge clk_i);
        mcu_req = 1'b0;
        check(acks === 1'b1 && host_won === 1'b1, "host write never reached bus");
        check(mem[15'h0030] === 16'h0F0F, "controller write lost");
        sc_read(16'h0060, 32'h0F0F_C0DE);
    endtask

    initial begin
        reset_i = 1'b1;
        addr_sel_i = 1'b0;
        mcu_req = 1'b0;
        mcu_we = 1'b0;
        mcu_addr = '0;
        mcu_wdata = '0;
        repeat (10) @(negedge clk_i);
        check(sda_oe === 1'b0 && mem_req === 1'b0, "port active in reset");
        reset_i = 1'b0;
        @(negedge clk_i);
        sc_address();
        sc_read(16'h0040, 32'h1234_5678);
        sc_arbitration();
        complete_run();
    end

    // Cuts a hang short.
    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        complete_run();
    end
endmodule
